//--- hw/mlbd_defs.svh
/*
 Constants for the literal and bit-operation decode core: opcode fields,
 register offsets, reset values and cycle counts.
 Assumes inclusion by bare name from the core, the checker and the bench.
*/
// Behaviour
// (RULE1) 00 0110 d fffffff: XOR accumulator with file, one cycle, zero flag only.
// (RULE2) 01 00bb b fffffff: clear selected file bit, one cycle, no flags.
// (RULE3) 01 01bb b fffffff: set selected file bit, one cycle, no flags.
// (RULE4) 01 10bb: skip next instruction when selected bit is zero, two cycles then.
// (RULE5) 01 11bb: skip next instruction when selected bit is one, flags unchanged.
// (RULE6) Taken skip or program counter change runs second cycle as no-operation.
// (RULE7) 10 0k: call, 10 1k: jump; load 11-bit target, two cycles.
// (RULE8) Return with literal, plain return, return from interrupt; two cycles each.
// (RULE9) Add literal to accumulator; update carry, half carry and zero.
// (RULE10) AND literal into accumulator; update zero only.
// (RULE11) OR literal into accumulator, one cycle; update zero only.
// (RULE12) XOR literal into accumulator, one cycle; update zero only.
// (RULE13) Literal minus accumulator into accumulator; update carry, half carry, zero.
// (RULE14) Sleep enters standby, updates timeout and powerdown; decode watchdog clear.
// (RULE15) Add accumulator and file register in one cycle; carry, half carry, zero.
// (RULE16) Byte file operations: destination zero to accumulator, one to file.
// (RULE17) Port register modified from itself reads pin levels, not the latch.
// (RULE18) File write to timer zero clears its prescaler when assigned to it.
// (RULE19) Watchdog clear zeroes watchdog and prescaler, sets timeout and powerdown.
// (RULE20) One instruction cycle spans four oscillator periods.
// (RULE21) Zero from 8-bit result, carry from bit 7, half carry from bit 3.
`ifndef MLBD_DEFS_SVH
`define MLBD_DEFS_SVH

`define MLBD_PHASES        3'h4
`define MLBD_PHASE_LAST    2'h3
`define MLBD_PHASE_WSETUP  2'h2

`define MLBD_OFF_CTRL      12'h000
`define MLBD_OFF_ACC       12'h004
`define MLBD_OFF_STATUS    12'h008
`define MLBD_OFF_PC        12'h00c
`define MLBD_OFF_OPTION    12'h010

`define MLBD_CTRL_RUN      0
`define MLBD_CTRL_WAKE     1
`define MLBD_OPT_PSA_WDT   0
`define MLBD_OPT_GIE       1

`define MLBD_ST_C          0
`define MLBD_ST_DC         1
`define MLBD_ST_Z          2
`define MLBD_ST_PD         3
`define MLBD_ST_TO         4
`define MLBD_ST_RESET      5'h18

`define MLBD_ADDR_TIMER_ZERO_COUNT     7'h01
`define MLBD_ADDR_PORT_LO  7'h05
`define MLBD_ADDR_PORT_HI  7'h09

`define MLBD_OP_RETURN     14'h0008
`define MLBD_OP_RETURN_FROM_INTERRUPT     14'h0009
`define MLBD_OP_SLEEP      14'h0063
`define MLBD_OP_WATCHDOG_CLEAR_OP     14'h0064

`endif

//--- hw/mlbd_pkg.sv
/*
 Types for the decode core: executed operations and the ALU result bundle.
 Assumes nothing beyond the constants header.
*/
package mlbd_pkg;
	typedef enum logic [4:0] {
		MLBD_NOP    = 5'b00000,
		MLBD_XOR_ACC_WITH_FILE  = 5'b00001,
		MLBD_ADD_ACC_AND_FILE  = 5'b00010,
		MLBD_BCLR   = 5'b00011,
		MLBD_BSET   = 5'b00100,
		MLBD_SKCLR  = 5'b00101,
		MLBD_SKSET  = 5'b00110,
		MLBD_CALL   = 5'b00111,
		MLBD_JUMP   = 5'b01000,
		MLBD_RETLIT = 5'b01001,
		MLBD_RET    = 5'b01010,
		MLBD_RETINT = 5'b01011,
		MLBD_ADDLIT = 5'b01100,
		MLBD_ANDLIT = 5'b01101,
		MLBD_ORLIT  = 5'b01110,
		MLBD_XORLIT = 5'b01111,
		MLBD_SUBLIT = 5'b10000,
		MLBD_MOVLIT = 5'b10001,
		MLBD_SLEEP  = 5'b10010,
		MLBD_WDCLR  = 5'b10011
	} mlbd_op_t;

	typedef struct packed {
		logic [7:0] res;
		logic       c;
		logic       dc;
		logic       z;
	} mlbd_alu_t;

	typedef struct packed {
		logic [6:0] addr;
		logic [7:0] wdata;
		logic       we;
	} mlbd_file_t;
endpackage

//--- hw/mlbd_core.sv
/*
 Instruction decode and execute core: XOR/add file ops, bit ops, literal and
 control ops, status flags, an 8-deep call stack and an APB register window.
 Assumes program memory returns instr_data combinationally for pc, the data
 file returns file_rdata combinationally for file.addr and writes on the clock
 edge where file.we is high. pclk is the oscillator.
*/
// Implementation choices: the address map and register access over APB.
`timescale 1ns/100ps
`include "mlbd_defs.svh"

module mlbd_core
	import mlbd_pkg::*;
#(
	parameter int PC_W    = 13,
	parameter int STACK_D = 8
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	output logic      [PC_W-1:0]   pc,
	input  wire logic [13:0]       instr_data,
	input  wire logic [1:0]        pc_upper,
	output mlbd_file_t             file,
	input  wire logic [7:0]        file_rdata,
	input  wire logic [7:0]        pin_levels,
	output logic                   timer_zero_count_presc_clr,
	output logic                   wdt_clr,
	output logic                   standby,
	output logic                   gie
);
	localparam int SP_W = $clog2(STACK_D);

	logic [1:0]      phase_r;
	logic [13:0]     ir_r;
	logic            flush_r;
	logic [PC_W-1:0] pc_r;
	logic [7:0]      acc_r;
	logic [4:0]      status_r;
	logic            run_r;
	logic            psa_wdt_r;
	logic            gie_r;
	logic            sleep_r;
	logic [PC_W-1:0] stack_r [STACK_D];
	logic [SP_W-1:0] sp_r;
	mlbd_file_t      file_r;
	logic            presc_clr_r;
	logic            wdt_clr_r;
	logic [31:0]     prdata_r;
	logic            pready_r;
	logic            pslverr_r;

	function automatic mlbd_op_t decode(input logic [13:0] w);
		mlbd_op_t op;
		op = MLBD_NOP;
		case (w[13:12])
			2'b00: begin
				if (w[11:8] == 4'h6)
					op = MLBD_XOR_ACC_WITH_FILE; // RULE1
				else if (w[11:8] == 4'h7)
					op = MLBD_ADD_ACC_AND_FILE; // RULE15
				else if (w == `MLBD_OP_RETURN)
					op = MLBD_RET; // RULE8
				else if (w == `MLBD_OP_RETURN_FROM_INTERRUPT)
					op = MLBD_RETINT; // RULE8
				else if (w == `MLBD_OP_SLEEP)
					op = MLBD_SLEEP; // RULE14
				else if (w == `MLBD_OP_WATCHDOG_CLEAR_OP)
					op = MLBD_WDCLR; // RULE14
			end
			2'b01: begin
				case (w[11:10])
					2'b00:   op = MLBD_BCLR; // RULE2
					2'b01:   op = MLBD_BSET; // RULE3
					2'b10:   op = MLBD_SKCLR; // RULE4
					default: op = MLBD_SKSET; // RULE5
				endcase
			end
			2'b10: op = w[11] ? MLBD_JUMP : MLBD_CALL; // RULE7
			default: begin
				casez (w[11:8])
					4'b111?: op = MLBD_ADDLIT; // RULE9
					4'b1001: op = MLBD_ANDLIT; // RULE10
					4'b1000: op = MLBD_ORLIT; // RULE11
					4'b1010: op = MLBD_XORLIT; // RULE12
					4'b110?: op = MLBD_SUBLIT; // RULE13
					4'b01??: op = MLBD_RETLIT; // RULE8
					4'b00??: op = MLBD_MOVLIT;
					default: op = MLBD_NOP;
				endcase
			end
		endcase
		return op;
	endfunction

	// Subtraction passes ~b with carry in of one, so carry is inverted borrow
	function automatic mlbd_alu_t add8(input logic [7:0] a, input logic [7:0] b, input logic cin);
		mlbd_alu_t r;
		logic [4:0] lo;
		logic [8:0] full;
		lo    = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		full  = {1'b0, a} + {1'b0, b} + {8'h00, cin};
		r.res = full[7:0];
		r.c   = full[8]; // RULE21
		r.dc  = lo[4]; // RULE21
		r.z   = (full[7:0] == 8'h00); // RULE21
		return r;
	endfunction

	// Decode and operands
	wire mlbd_op_t   op      = flush_r ? MLBD_NOP : decode(ir_r); // RULE6
	wire logic [7:0] lit     = ir_r[7:0];
	wire logic [2:0] bsel    = ir_r[9:7];
	wire logic       dest    = ir_r[7];
	wire logic [6:0] faddr   = ir_r[6:0];
	wire logic       is_port = (faddr >= `MLBD_ADDR_PORT_LO) && (faddr <= `MLBD_ADDR_PORT_HI);
	wire logic [7:0] fval    = is_port ? pin_levels : file_rdata; // RULE17
	wire logic [7:0] bmask   = 8'h01 << bsel;
	wire logic       bit_val = |(fval & bmask);

	wire mlbd_alu_t  sum_wf  = add8(acc_r, fval, 1'b0); // RULE15
	wire mlbd_alu_t  sum_lw  = add8(lit, acc_r, 1'b0); // RULE9
	wire mlbd_alu_t  dif_lw  = add8(lit, ~acc_r, 1'b1); // RULE13
	wire logic [7:0] xor_wf  = acc_r ^ fval; // RULE1

	wire logic       is_byte = (op == MLBD_XOR_ACC_WITH_FILE) || (op == MLBD_ADD_ACC_AND_FILE);
	wire logic       is_bit  = (op == MLBD_BCLR) || (op == MLBD_BSET);
	wire logic [7:0] byte_res = (op == MLBD_ADD_ACC_AND_FILE) ? sum_wf.res : xor_wf;
	wire logic       to_file = (is_byte && dest) || is_bit; // RULE16
	wire logic [7:0] bit_res = (op == MLBD_BSET) ? (fval | bmask) : (fval & ~bmask); // RULE2 RULE3
	wire logic [7:0] file_res = is_bit ? bit_res : byte_res;

	wire logic       skip_t  = ((op == MLBD_SKCLR) && !bit_val) || ((op == MLBD_SKSET) && bit_val); // RULE4 RULE5
	wire logic       is_ret  = (op == MLBD_RET) || (op == MLBD_RETLIT) || (op == MLBD_RETINT);
	wire logic       is_br   = (op == MLBD_CALL) || (op == MLBD_JUMP);
	wire logic       take_2  = skip_t || is_ret || is_br; // RULE6

	wire logic [SP_W-1:0] sp_pop = sp_r - SP_W'(1);
	wire logic [PC_W-1:0] br_tgt = PC_W'({pc_upper, ir_r[10:0]}); // RULE7
	wire logic [PC_W-1:0] pc_nxt = is_br ? br_tgt : (is_ret ? stack_r[sp_pop] : pc_r + PC_W'(1));

	// Execute boundaries: one instruction per four oscillator periods
	wire logic active  = run_r && !sleep_r;
	wire logic ex_edge = active && (phase_r == `MLBD_PHASE_LAST); // RULE20
	wire logic wsetup  = active && (phase_r == `MLBD_PHASE_WSETUP);

	// Accumulator and flags
	logic [7:0] acc_nxt;
	logic [4:0] status_nxt;
	always_comb begin
		acc_nxt    = acc_r;
		status_nxt = status_r;
		case (op)
			MLBD_XOR_ACC_WITH_FILE, MLBD_ADD_ACC_AND_FILE: begin
				if (!dest)
					acc_nxt = byte_res; // RULE16
				status_nxt[`MLBD_ST_Z] = (byte_res == 8'h00); // RULE1 RULE15
				if (op == MLBD_ADD_ACC_AND_FILE) begin
					status_nxt[`MLBD_ST_C]  = sum_wf.c; // RULE15
					status_nxt[`MLBD_ST_DC] = sum_wf.dc;
				end
			end
			MLBD_ADDLIT: begin
				acc_nxt = sum_lw.res; // RULE9
				status_nxt[`MLBD_ST_C]  = sum_lw.c;
				status_nxt[`MLBD_ST_DC] = sum_lw.dc;
				status_nxt[`MLBD_ST_Z]  = sum_lw.z;
			end
			MLBD_SUBLIT: begin
				acc_nxt = dif_lw.res; // RULE13
				status_nxt[`MLBD_ST_C]  = dif_lw.c;
				status_nxt[`MLBD_ST_DC] = dif_lw.dc;
				status_nxt[`MLBD_ST_Z]  = dif_lw.z;
			end
			MLBD_ANDLIT, MLBD_ORLIT, MLBD_XORLIT: begin
				if (op == MLBD_ANDLIT)
					acc_nxt = acc_r & lit; // RULE10
				else if (op == MLBD_ORLIT)
					acc_nxt = acc_r | lit; // RULE11
				else
					acc_nxt = acc_r ^ lit; // RULE12
				status_nxt[`MLBD_ST_Z] = (acc_nxt == 8'h00);
			end
			MLBD_RETLIT, MLBD_MOVLIT: acc_nxt = lit; // RULE8
			MLBD_SLEEP: begin
				status_nxt[`MLBD_ST_TO] = 1'b1; // RULE14
				status_nxt[`MLBD_ST_PD] = 1'b0;
			end
			MLBD_WDCLR: begin
				status_nxt[`MLBD_ST_TO] = 1'b1; // RULE19
				status_nxt[`MLBD_ST_PD] = 1'b1;
			end
			default: begin
				acc_nxt    = acc_r;
				status_nxt = status_r;
			end
		endcase
	end

	// APB decode: zero-wait slave, data latched in the setup cycle
	wire logic setup   = psel && !penable;
	wire logic wr_acc  = psel && penable && pwrite && pready_r;
	wire logic hit_ctl = (paddr == `MLBD_OFF_CTRL);
	wire logic hit_acc = (paddr == `MLBD_OFF_ACC);
	wire logic hit_st  = (paddr == `MLBD_OFF_STATUS);
	wire logic hit_pc  = (paddr == `MLBD_OFF_PC);
	wire logic hit_opt = (paddr == `MLBD_OFF_OPTION);
	wire logic mapped  = hit_ctl || hit_acc || hit_st || hit_pc || hit_opt;
	wire logic [31:0] rd_mux =
		hit_ctl ? {30'h0000_0000, sleep_r, run_r} :
		hit_acc ? {24'h00_0000, acc_r} :
		hit_st  ? {27'h000_0000, status_r} :
		hit_pc  ? {{(32-PC_W){1'b0}}, pc_r} :
		hit_opt ? {30'h0000_0000, gie_r, psa_wdt_r} : 32'h0000_0000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r  <= 32'h0000_0000;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			pready_r  <= setup;
			pslverr_r <= setup && !mapped;
			prdata_r  <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	// Phase counter; held at zero while stopped so a restart begins cleanly
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			phase_r <= 2'h0;
		else
			phase_r <= active ? phase_r + 2'h1 : 2'h0; // RULE20
	end

	// Fetch, program counter, flush and stack
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ir_r    <= 14'h0000;
			flush_r <= 1'b1;
			pc_r    <= '0;
			sp_r    <= '0;
		end else if (ex_edge) begin
			ir_r    <= instr_data;
			flush_r <= take_2; // RULE6
			pc_r    <= pc_nxt; // RULE7 RULE8
			if (op == MLBD_CALL)
				sp_r <= sp_r + SP_W'(1);
			else if (is_ret)
				sp_r <= sp_pop;
		end
	end

	always_ff @(posedge pclk) begin
		if (ex_edge && (op == MLBD_CALL))
			stack_r[sp_r] <= pc_r; // RULE7
	end

	// File port: address follows the fetched word, write strobe covers the last phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			file_r      <= '0;
			presc_clr_r <= 1'b0;
		end else begin
			if (ex_edge)
				file_r.addr <= instr_data[6:0];
			file_r.we    <= wsetup && to_file; // RULE2 RULE3 RULE16
			file_r.wdata <= wsetup ? file_res : file_r.wdata;
			presc_clr_r  <= wsetup && to_file && (faddr == `MLBD_ADDR_TIMER_ZERO_COUNT) && !psa_wdt_r; // RULE18
		end
	end

	// Accumulator, status and control; the core's update wins over a software write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_r     <= 8'h00;
			status_r  <= `MLBD_ST_RESET;
			run_r     <= 1'b0;
			psa_wdt_r <= 1'b0;
			gie_r     <= 1'b0;
			sleep_r   <= 1'b0;
			wdt_clr_r <= 1'b0;
		end else begin
			wdt_clr_r <= ex_edge && (op == MLBD_WDCLR); // RULE19
			if (ex_edge) begin
				acc_r    <= acc_nxt;
				status_r <= status_nxt;
			end else if (wr_acc && hit_acc)
				acc_r <= pwdata[7:0];
			else if (wr_acc && hit_st)
				status_r <= pwdata[4:0];
			if (ex_edge && (op == MLBD_SLEEP))
				sleep_r <= 1'b1; // RULE14
			else if (wr_acc && hit_ctl && pwdata[`MLBD_CTRL_WAKE])
				sleep_r <= 1'b0;
			if (wr_acc && hit_ctl)
				run_r <= pwdata[`MLBD_CTRL_RUN];
			if (ex_edge && (op == MLBD_RETINT))
				gie_r <= 1'b1; // RULE8
			else if (wr_acc && hit_opt)
				gie_r <= pwdata[`MLBD_OPT_GIE];
			if (wr_acc && hit_opt)
				psa_wdt_r <= pwdata[`MLBD_OPT_PSA_WDT];
		end
	end

	assign prdata         = prdata_r;
	assign pready         = pready_r;
	assign pslverr        = pslverr_r;
	assign pc             = pc_r;
	assign file           = file_r;
	assign timer_zero_count_presc_clr = presc_clr_r;
	assign wdt_clr        = wdt_clr_r;
	assign standby        = sleep_r;
	assign gie            = gie_r;
endmodule // mlbd_core

//--- sim/mlbd_core_assertions.sv
/*
 Checker for the decode core: APB answer timing, instruction-cycle cadence,
 file write pulses, prescaler clear cause and standby.
 Assumes it is bound to mlbd_core, whose port names it repeats.
*/
`timescale 1ns/100ps
`include "mlbd_defs.svh"

module mlbd_core_assertions
	import mlbd_pkg::*;
#(
	parameter int PC_W    = 13,
	parameter int STACK_D = 8
) (
	input wire logic            pclk,
	input wire logic            presetn,
	input wire logic            psel,
	input wire logic            penable,
	input wire logic            pwrite,
	input wire logic [11:0]     paddr,
	input wire logic [31:0]     pwdata,
	input wire logic [31:0]     prdata,
	input wire logic            pready,
	input wire logic            pslverr,
	input wire logic [PC_W-1:0] pc,
	input wire mlbd_file_t      file,
	input wire logic            timer_zero_count_presc_clr,
	input wire logic            wdt_clr,
	input wire logic            standby
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	logic wake_req;
	assign wake_req = psel && penable && pwrite && paddr == `MLBD_OFF_CTRL && pwdata[`MLBD_CTRL_WAKE];

	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_no_we3;
		!file.we [*3];
	endsequence

	a_ready_next: assert property (s_setup |=> pready) else $error("ready missing after setup");
	a_ready_pulse: assert property (pready |=> !pready) else $error("ready held two cycles");
	a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
	a_rdata_quiet: assert property (!pready |-> prdata == 32'h0000_0000) else $error("read data outside access");
	a_pc_cadence: assert property ($changed(pc) |=> $stable(pc) [*3]) else $error("pc moved mid cycle");
	a_we_single: assert property (file.we |=> s_no_we3) else $error("file write not single");
	a_we_addr_held: assert property (file.we |-> $stable(file.addr)) else $error("file address moved");
	a_presc_cause: assert property (timer_zero_count_presc_clr |-> file.we && file.addr == `MLBD_ADDR_TIMER_ZERO_COUNT)
		else $error("prescaler clear without timer write");
	a_wdt_single: assert property (wdt_clr |=> !wdt_clr [*3]) else $error("watchdog clear repeated");
	a_standby_held: assert property (standby && !wake_req |=> standby) else $error("standby left");
	a_standby_frozen: assert property (standby ##1 standby |-> $stable(pc)) else $error("pc moved in standby");
endmodule // mlbd_core_assertions

bind mlbd_core mlbd_core_assertions #(
	.PC_W   (PC_W),
	.STACK_D(STACK_D)
) i_mlbd_core_assertions (
	.pclk          (pclk),
	.presetn       (presetn),
	.psel          (psel),
	.penable       (penable),
	.pwrite        (pwrite),
	.paddr         (paddr),
	.pwdata        (pwdata),
	.prdata        (prdata),
	.pready        (pready),
	.pslverr       (pslverr),
	.pc            (pc),
	.file          (file),
	.timer_zero_count_presc_clr(timer_zero_count_presc_clr),
	.wdt_clr       (wdt_clr),
	.standby       (standby)
);

//--- sim/mlbd_mem_model.sv
/*
 Program memory and data file behind the decode core.
 Assumes the bench loads prog and data between runs.
*/
`timescale 1ns/100ps

module mlbd_mem_model
	import mlbd_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic [12:0] pc,
	input  wire mlbd_file_t  file,
	output logic      [13:0] instr_data,
	output logic      [7:0]  file_rdata
);
	logic [13:0] prog [0:8191];
	logic [7:0]  data [0:127];

	assign instr_data = prog[pc];
	assign file_rdata = data[file.addr];

	always @(posedge pclk) begin
		if (file.we === 1'b1) begin
			data[file.addr] <= file.wdata;
		end
	end
endmodule // mlbd_mem_model

//--- sim/mlbd_core_test.sv
/*
 Self-checking bench: a table of short programs, then wake from standby,
 prescaler ownership, a far jump, reset values and APB refusals.
 Assumes mlbd_mem_model as program and data memory.
*/
`timescale 1ns/100ps
`include "mlbd_defs.svh"

module mlbd_core_test
	import mlbd_pkg::*;
;
	typedef struct packed {
		logic [13:0] i0, i1;
		logic [7:0]  acc, fv;
		logic [4:0]  st;
		logic [7:0]  eacc, efv;
		logic [4:0]  est;
		logic [3:0]  ev;
	} mlbd_row_t;

	localparam logic [13:0] NW = 14'h0000;
	localparam logic [13:0] A1 = 14'h3e01;
	// Program: slot 0 and 1 from the row, then a loop at 2 and subroutines at 3..5
	localparam mlbd_row_t ROWS [24] = '{
		'{14'h0620,NW,8'h5a,8'h5a,5'h1b,8'h00,8'h5a,5'h1f,4'h0},
		'{14'h0720,NW,8'h88,8'h88,5'h18,8'h10,8'h88,5'h1b,4'h0},
		'{14'h07a0,NW,8'h01,8'hff,5'h18,8'h01,8'h00,5'h1f,4'h0},
		'{14'h13a0,NW,8'h00,8'hff,5'h1f,8'h00,8'h7f,5'h1f,4'h0},
		'{14'h1420,NW,8'h00,8'h00,5'h18,8'h00,8'h01,5'h18,4'h0},
		'{14'h3e01,NW,8'hff,8'h00,5'h18,8'h00,8'h00,5'h1f,4'h0},
		'{14'h3f08,NW,8'h07,8'h00,5'h1f,8'h0f,8'h00,5'h18,4'h0},
		'{14'h390f,NW,8'hf0,8'h00,5'h1b,8'h00,8'h00,5'h1f,4'h0},
		'{14'h3880,NW,8'h01,8'h00,5'h1f,8'h81,8'h00,5'h1b,4'h0},
		'{14'h3aff,NW,8'h0f,8'h00,5'h1c,8'hf0,8'h00,5'h18,4'h0},
		'{14'h3c05,NW,8'h05,8'h00,5'h18,8'h00,8'h00,5'h1f,4'h0},
		'{14'h3d03,NW,8'h04,8'h00,5'h1f,8'hff,8'h00,5'h18,4'h0},
		'{14'h19a0,A1,8'h10,8'h00,5'h18,8'h10,8'h00,5'h18,4'h0},
		'{14'h19a0,A1,8'h10,8'h08,5'h18,8'h11,8'h08,5'h18,4'h0},
		'{14'h1da0,A1,8'h10,8'h08,5'h18,8'h10,8'h08,5'h18,4'h0},
		'{14'h1da0,A1,8'h10,8'hf7,5'h18,8'h11,8'hf7,5'h18,4'h0},
		'{14'h2802,A1,8'h10,8'h00,5'h18,8'h10,8'h00,5'h18,4'h0},
		'{14'h2003,A1,8'h00,8'h00,5'h18,8'h43,8'h00,5'h18,4'h0},
		'{14'h2004,A1,8'h20,8'h00,5'h18,8'h21,8'h00,5'h18,4'h0},
		'{14'h2005,A1,8'h30,8'h00,5'h18,8'h31,8'h00,5'h18,4'h4},
		'{14'h0685,NW,8'hff,8'h00,5'h18,8'hff,8'h5a,5'h18,4'h0},
		'{14'h1401,NW,8'h00,8'h00,5'h18,8'h00,8'h01,5'h18,4'h1},
		'{14'h0064,NW,8'h00,8'h00,5'h00,8'h00,8'h00,5'h18,4'h2},
		'{14'h0063,NW,8'h00,8'h00,5'h07,8'h00,8'h00,5'h17,4'h8}
	};
	localparam mlbd_row_t OWNED = '{14'h1401,NW,8'h00,8'h00,5'h18,8'h00,8'h01,5'h18,4'h0};
	// Jump to 3 lands on sleep only when the upper target bits come from pc_upper
	localparam mlbd_row_t FAR_JUMP = '{14'h2803,A1,8'h00,8'h00,5'h18,8'h00,8'h00,5'h10,4'h8};

	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        timer_zero_count_presc_clr, wdt_clr, standby, gie, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [12:0] pc;
	logic [13:0] instr_data;
	logic [7:0]  file_rdata, pin_levels;
	logic [1:0]  pc_upper;
	mlbd_file_t  file;
	int          n_errors, samples_checked, n_presc, n_wdt;

	mlbd_core i_mlbd_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pc(pc), .instr_data(instr_data), .pc_upper(pc_upper), .file(file),
		.file_rdata(file_rdata), .pin_levels(pin_levels), .timer_zero_count_presc_clr(timer_zero_count_presc_clr),
		.wdt_clr(wdt_clr), .standby(standby), .gie(gie));
	mlbd_mem_model i_mlbd_mem_model (.pclk(pclk), .pc(pc), .file(file),
		.instr_data(instr_data), .file_rdata(file_rdata));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		n_wdt += int'(wdt_clr === 1'b1);
		n_presc += int'(timer_zero_count_presc_clr === 1'b1);
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the bench watchdog ends a wait that never sees pready
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic hold_reset();
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
	endtask

	// Reset first, so each program starts from pc 0 even while the last one loops
	task automatic run_row(input mlbd_row_t r, input logic [31:0] opt);
		hold_reset();
		i_mlbd_mem_model.prog[0] = r.i0;
		i_mlbd_mem_model.prog[1] = r.i1;
		i_mlbd_mem_model.data[r.i0[6:0]] = r.fv;
		n_presc = 0;
		n_wdt = 0;
		apb(1'b1, `MLBD_OFF_ACC, {24'h0, r.acc});
		apb(1'b1, `MLBD_OFF_STATUS, {27'h0, r.st});
		apb(1'b1, `MLBD_OFF_OPTION, opt);
		apb(1'b1, `MLBD_OFF_CTRL, 32'h0000_0001);
		repeat (80) @(posedge pclk);
		apb(1'b0, `MLBD_OFF_ACC, 32'h0);
		check("acc", q, {24'h0, r.eacc});
		apb(1'b0, `MLBD_OFF_STATUS, 32'h0);
		check("status", q, {27'h0, r.est});
		check("file", {24'h0, i_mlbd_mem_model.data[r.i0[6:0]]}, {24'h0, r.efv});
		check("events", {28'h0, standby, gie, n_wdt == 1, n_presc == 1}, {28'h0, r.ev});
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge pclk);
		n_errors++;
		complete_run();
	end

	initial begin
		presetn    <= 1'b0;
		psel       <= 1'b0;
		penable    <= 1'b0;
		pwrite     <= 1'b0;
		paddr      <= 12'h000;
		pwdata     <= 32'h0000_0000;
		pin_levels <= 8'ha5;
		pc_upper   <= 2'h0;
		for (int k = 0; k < 128; k++) begin
			i_mlbd_mem_model.data[k] = 8'h00;
		end
		i_mlbd_mem_model.prog[2] = 14'h2802;
		i_mlbd_mem_model.prog[3] = 14'h3442;
		i_mlbd_mem_model.prog[4] = 14'h0008;
		i_mlbd_mem_model.prog[5] = 14'h0009;
		foreach (ROWS[k]) begin
			run_row(ROWS[k], 32'h0);
			$display("row %0d done", k);
		end
		apb(1'b1, `MLBD_OFF_CTRL, 32'h0000_0003);
		@(posedge pclk);
		check("wake", {31'h0, standby}, 32'h0);
		$display("wake done");
		run_row(OWNED, 32'h0000_0001);
		$display("prescaler owned by watchdog done");
		pc_upper <= 2'h1;
		i_mlbd_mem_model.prog[13'h0803] = `MLBD_OP_SLEEP;
		i_mlbd_mem_model.prog[13'h0804] = NW;
		run_row(FAR_JUMP, 32'h0);
		apb(1'b0, `MLBD_OFF_PC, 32'h0);
		check("pc register", q, 32'h0000_0805);
		check("pc pin", {19'h0, pc}, 32'h0000_0805);
		pc_upper <= 2'h0;
		$display("far jump done");
		hold_reset();
		apb(1'b1, `MLBD_OFF_PC, 32'h0000_0055);
		for (int k = 0; k < 6; k++) begin
			apb(1'b0, 12'(k * 4), 32'h0);
			check("reset value", q, (k == 2) ? 32'h0000_0018 : 32'h0);
			check("slave error", {31'h0, e}, {31'h0, k == 5});
		end
		$display("register map done");
		complete_run();
	end
endmodule // mlbd_core_test
